// ==== rtl/address_history_stack.sv ====
`timescale 1ns/100ps
`include "addr_stack_defines.svh"
module address_history_stack
  import addr_stack_pkg::*;
#(
  parameter int DEPTH = `STACK_DEPTH
) (
  input  wire logic MCLK,          // 25 MHz system clock
  input  wire logic RST_N,         // Synchronous reset, active low
  input  wire logic ALE,           // Address latch strobe pin
  input  wire logic RD_N,          // Read strobe pin, active low
  input  wire logic CS_N,          // Chip select pin, active low
  input  wire logic [7:0] AD_IN,   // Multiplexed bus, pin level
  output logic [7:0] AD_OUT,       // Read data driven onto bus
  output logic AD_OE_N,            // Bus drive enable, low drives
  input  wire logic BANK_SEL,      // Bank select bit from control A
  output logic [7:0] LATCHED_ADDR, // Address of current access
  output logic STACK_SEL           // Current address hits the stack
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  bus_sample_t pin_s1_r;
  bus_sample_t pin_s2_r;
  bus_sample_t pin_s3_r;
  bus_sample_t pin_now;

  assign pin_now = '{ale: ALE, rd_n: RD_N, cs_n: CS_N, ad: AD_IN};

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      pin_s1_r <= '{ale: 1'b0, rd_n: 1'b1, cs_n: 1'b1, ad: `ADDR_RESET};
      pin_s2_r <= '{ale: 1'b0, rd_n: 1'b1, cs_n: 1'b1, ad: `ADDR_RESET};
    end else begin
      pin_s1_r <= pin_now;
      pin_s2_r <= pin_s1_r;
    end
  end

  // Delayed copy for the strobe edge and the address that went with it
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      pin_s3_r <= '{ale: 1'b0, rd_n: 1'b1, cs_n: 1'b1, ad: `ADDR_RESET};
    end else begin
      pin_s3_r <= pin_s2_r;
    end
  end

  // ****************************************************************
  // Address capture
  // ****************************************************************
  logic  ale_fall;
  addr_t capture_addr;

  // Falling strobe; address taken from the sample while still high
  assign ale_fall     = pin_s3_r.ale & ~pin_s2_r.ale;
  assign capture_addr = pin_s3_r.ad;

  // ****************************************************************
  // History stack
  // ****************************************************************
  logic [DEPTH-1:0][`ADDR_WIDTH-1:0] entries;

  // Each capture pushes; the oldest slot falls off the end
  history_shift #(
    .DEPTH (DEPTH),
    .WIDTH (`ADDR_WIDTH)
  ) u_history (
    .clk     (MCLK),
    .rst_n   (RST_N),
    .push    (ale_fall),
    .din     (capture_addr),
    .entries (entries)
  );

  addr_t cur_addr;
  addr_t prev_addr;
  addr_t older_addr;

  assign cur_addr   = entries[`IDX_CURRENT];
  assign prev_addr  = entries[`IDX_PREV];
  assign older_addr = entries[`IDX_OLDER];

  // ****************************************************************
  // Read decode
  // ****************************************************************
  logic rd_active;
  logic hit_older;
  logic hit_prev;
  logic stack_hit;

  assign rd_active = ~pin_s2_r.cs_n & ~pin_s2_r.rd_n;
  assign hit_older = BANK_SEL && (cur_addr == `OFS_OLDER_SLOT);
  assign hit_prev  = BANK_SEL && (cur_addr == `OFS_PREV_SLOT);
  assign stack_hit = hit_older | hit_prev;

  // ****************************************************************
  // Bus drive
  // ****************************************************************
  addr_t rd_data_r;
  logic  oe_n_r;
  logic  stack_sel_r;
  addr_t latched_r;

  // Slots are read only; writes to them are simply not decoded
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      rd_data_r <= `ADDR_RESET;
    end else if (hit_older) begin
      rd_data_r <= older_addr;
    end else if (hit_prev) begin
      rd_data_r <= prev_addr;
    end else begin
      rd_data_r <= `ADDR_RESET;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      oe_n_r <= 1'b1;
    end else begin
      oe_n_r <= ~(rd_active & stack_hit);
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      stack_sel_r <= 1'b0;
      latched_r   <= `ADDR_RESET;
    end else begin
      stack_sel_r <= stack_hit;
      latched_r   <= cur_addr;
    end
  end

  assign AD_OUT       = rd_data_r;
  assign AD_OE_N      = oe_n_r;
  assign STACK_SEL    = stack_sel_r;
  assign LATCHED_ADDR = latched_r;

  // ****************************************************************
  // Check helpers
  // ****************************************************************
  logic [1:0] since_mark_r;
  addr_t      mark_addr_r;
  addr_t      cap1_r;
  addr_t      cap2_r;

  // Follows one captured address through the next three pushes
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      since_mark_r <= 2'h3;
      mark_addr_r  <= `ADDR_RESET;
    end else if (ale_fall) begin
      if (since_mark_r == 2'h3) begin
        since_mark_r <= 2'h0;
        mark_addr_r  <= capture_addr;
      end else begin
        since_mark_r <= since_mark_r + 2'h1;
      end
    end
  end

  // Last two captures, kept apart from the stack itself
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      cap1_r <= `ADDR_RESET;
      cap2_r <= `ADDR_RESET;
    end else if (ale_fall) begin
      cap1_r <= capture_addr;
      cap2_r <= cap1_r;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_capture_fall: assert property (
    @(posedge MCLK) disable iff (!RST_N)
    ($past(pin_s2_r.ale) && !pin_s2_r.ale)
      |=> (cur_addr == $past(pin_s3_r.ad))
  ) else $error("address not captured on strobe fall");

  a_push_shift: assert property (
    @(posedge MCLK) disable iff (!RST_N)
    ale_fall |=> (prev_addr == $past(cur_addr))
      && (older_addr == $past(prev_addr))
  ) else $error("stack did not shift on capture");

  a_depth_drop: assert property (
    @(posedge MCLK) disable iff (!RST_N)
    ale_fall |=> (entries[DEPTH-1] == $past(entries[DEPTH-2]))
  ) else $error("oldest slot not replaced on push");

  a_hold_idle: assert property (
    @(posedge MCLK) disable iff (!RST_N)
    !ale_fall |=> $stable(entries)
  ) else $error("stack changed without a capture");

  a_four_back: assert property (
    @(posedge MCLK) disable iff (!RST_N)
    (ale_fall && since_mark_r == 2'h2)
      |=> (entries[DEPTH-1] == mark_addr_r)
  ) else $error("entry lost before four pushes");

  a_read_older: assert property (
    @(posedge MCLK) disable iff (!RST_N)
    (rd_active && BANK_SEL && cur_addr == 8'h4E)
      |=> (!AD_OE_N && AD_OUT == $past(older_addr))
  ) else $error("offset 4Eh did not return two-back address");

  a_read_prev: assert property (
    @(posedge MCLK) disable iff (!RST_N)
    (rd_active && BANK_SEL && cur_addr == 8'h4F)
      |=> (!AD_OE_N && AD_OUT == $past(prev_addr))
  ) else $error("offset 4Fh did not return previous address");

  a_drive_map: assert property (
    @(posedge MCLK) disable iff (!RST_N)
    !AD_OE_N |-> $past(BANK_SEL) && $past(rd_active)
      && ($past(cur_addr) == 8'h4E || $past(cur_addr) == 8'h4F)
  ) else $error("bus driven outside the stack locations");

  a_recover_seq: assert property (
    @(posedge MCLK) disable iff (!RST_N)
    (ale_fall && capture_addr == 8'h4E && cap1_r == 8'h0A)
      |=> (prev_addr == 8'h0A) && (older_addr == $past(cap2_r))
  ) else $error("recovery sequence did not stack bank access");

endmodule : address_history_stack

// ==== rtl/addr_stack_defines.svh ====
`ifndef ADDR_STACK_DEFINES_SVH
`define ADDR_STACK_DEFINES_SVH
// Notes on behaviour
// - History stack readable at extended offsets 4Eh, 4Fh.
// - Address captured at falling edge of latch strobe.
// - Every capture pushes stack one position older.
// - Four entries deep; oldest dropped on push.
// - Offset 4Eh returns address two captures back.

// ****************************************************************
// Offsets, widths and reset values
// ****************************************************************
`define STACK_DEPTH      4
`define ADDR_WIDTH       8
`define OFS_OLDER_SLOT   8'h4E
`define OFS_PREV_SLOT    8'h4F
`define IDX_CURRENT      0
`define IDX_PREV         1
`define IDX_OLDER        2
`define ADDR_RESET       8'h00
`define SYNC_STAGES      2
`endif

// ==== rtl/addr_stack_pkg.sv ====
package addr_stack_pkg;
  `include "addr_stack_defines.svh"

  typedef logic [`ADDR_WIDTH-1:0] addr_t;

  // One sample of the host bus pins
  typedef struct packed {
    logic  ale;
    logic  rd_n;
    logic  cs_n;
    addr_t ad;
  } bus_sample_t;
endpackage : addr_stack_pkg

// ==== rtl/history_shift.sv ====
`timescale 1ns/100ps
`include "addr_stack_defines.svh"
module history_shift
  import addr_stack_pkg::*;
#(
  parameter int DEPTH = `STACK_DEPTH,
  parameter int WIDTH = `ADDR_WIDTH
) (
  input  wire logic                        clk,     // System clock
  input  wire logic                        rst_n,   // Sync reset, low
  input  wire logic                        push,    // Shift in new entry
  input  wire logic [WIDTH-1:0]            din,     // Entry pushed
  output logic      [DEPTH-1:0][WIDTH-1:0] entries  // Index 0 is newest
);

  logic [WIDTH-1:0] slot_r [DEPTH];

  // ****************************************************************
  // Shift chain
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_slot
      logic [WIDTH-1:0] src;
      // Head takes the new entry, every other slot its younger neighbour
      if (g == 0) begin : g_head
        assign src = din;
      end else begin : g_tail
        assign src = slot_r[g-1];
      end
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          slot_r[g] <= WIDTH'(`ADDR_RESET);
        end else if (push) begin
          slot_r[g] <= src;
        end
      end
      assign entries[g] = slot_r[g];
    end
  endgenerate
endmodule : history_shift

// ==== test/host_model.sv ====
`timescale 1ns/100ps
module host_model
  import addr_stack_pkg::*;
(
  input  wire logic  clk,      // Bus clock
  input  wire logic  ad_oe_n,  // Device drives bus when low
  input  wire addr_t ad_out,   // Device read data
  output addr_t      ad_drv,   // Host side of the bus
  output logic       ale,      // Address latch strobe
  output logic       cs_n,     // Chip select, low
  output logic       rd_n,     // Read strobe, low
  output logic       bank_sel  // Bank select bit
);
  initial begin
    ad_drv   = 8'h00;
    ale      = 1'b0;
    cs_n     = 1'b1;
    rd_n     = 1'b1;
    bank_sel = 1'b1;
  end

  task automatic set_bank(input logic b);
    @(posedge clk) #1 bank_sel = b;
  endtask : set_bank

  // ****************************************************************
  // Address phase: hold the address past the strobe fall, then drive its complement
  // ****************************************************************
  task automatic latch(input addr_t a);
    @(posedge clk) #1 ad_drv = a;
    ale = 1'b1;
    repeat (2) @(posedge clk);
    #1 ale = 1'b0;
    repeat (2) @(posedge clk);
    #1 ad_drv = ~a;
    repeat (4) @(posedge clk);
  endtask : latch

  task automatic read(output addr_t d, output logic drv);
    d   = 8'h00;
    drv = 1'b0;
    @(posedge clk) #1 cs_n = 1'b0;
    rd_n = 1'b0;
    for (int i = 0; i < 8 && !drv; i++) begin
      @(negedge clk);
      if (ad_oe_n === 1'b0) begin
        d   = ad_out;
        drv = 1'b1;
      end
    end
    @(posedge clk) #1 cs_n = 1'b1;
    rd_n = 1'b1;
    repeat (5) @(posedge clk);
  endtask : read
endmodule : host_model

// ==== test/tb.sv ====
`timescale 1ns/100ps
module tb;
  import addr_stack_pkg::*;
  typedef struct packed {addr_t p2; addr_t p1; addr_t tgt; addr_t exp;} row_t;
  logic  mclk  = 1'b0;
  logic  rst_n = 1'b0;
  addr_t ad_drv, ad_out, ad_in, latched, d;
  logic  ale, cs_n, rd_n, bank, oe_n, ssel, drv;
  int    n_fail = 0;
  int    n_compared = 0;
  row_t  rows [4] = '{'{8'h11, 8'h0A, 8'h4E, 8'h11},
                      '{8'h22, 8'h33, 8'h4F, 8'h33},
                      '{8'h00, 8'hFF, 8'h4E, 8'h00},
                      '{8'h55, 8'h4E, 8'h4F, 8'h4E}};

  assign ad_in = oe_n ? ad_drv : ad_out;
  always #20 mclk = ~mclk;

  address_history_stack i_address_history_stack (
    .MCLK(mclk), .RST_N(rst_n), .ALE(ale), .RD_N(rd_n), .CS_N(cs_n),
    .AD_IN(ad_in), .AD_OUT(ad_out), .AD_OE_N(oe_n), .BANK_SEL(bank),
    .LATCHED_ADDR(latched), .STACK_SEL(ssel));
  host_model i_host_model (
    .clk(mclk), .ad_oe_n(oe_n), .ad_out(ad_out), .ad_drv(ad_drv),
    .ale(ale), .cs_n(cs_n), .rd_n(rd_n), .bank_sel(bank));

  task automatic chk8(input string n, input addr_t e, input addr_t g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk8

  task automatic chk1(input string n, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %b seen %b", n, e, g);
    end
  endtask : chk1

  task automatic summarize();
    if (n_fail == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  task automatic do_reset();
    @(posedge mclk) #1 rst_n = 1'b0;
    repeat (4) @(posedge mclk);
    #1 rst_n = 1'b1;
  endtask : do_reset

  task automatic seq3(input addr_t a, input addr_t b, input addr_t c);
    i_host_model.latch(a);
    i_host_model.latch(b);
    i_host_model.latch(c);
  endtask : seq3

  initial begin
    #100000;
    n_fail++;
    summarize();
  end

  initial begin
    repeat (4) @(posedge mclk);
    #1 rst_n = 1'b1;
    chk8("latched", 8'h00, latched);
    chk1("oe_n", 1'b1, oe_n);
    // ****************************************************************
    // Table rows: two earlier latches, then a stack slot
    // ****************************************************************
    foreach (rows[i]) begin
      seq3(rows[i].p2, rows[i].p1, rows[i].tgt);
      chk8("latched", rows[i].tgt, latched);
      chk1("stack_sel", 1'b1, ssel);
      i_host_model.read(d, drv);
      chk1("drive", 1'b1, drv);
      chk8("slot", rows[i].exp, d);
    end
    // A read is not a capture: the slot holds its value
    i_host_model.read(d, drv);
    chk8("reread", 8'h4E, d);
    // Unmapped extended offset is not driven
    seq3(8'h12, 8'h34, 8'h4D);
    i_host_model.read(d, drv);
    chk1("unmapped", 1'b0, drv);
    // Bank select clear refuses the stack
    i_host_model.set_bank(1'b0);
    seq3(8'h66, 8'h77, 8'h4E);
    chk1("stack_sel", 1'b0, ssel);
    i_host_model.read(d, drv);
    chk1("no_bank", 1'b0, drv);
    i_host_model.set_bank(1'b1);
    // Mid-run reset clears every slot
    do_reset();
    chk8("latched", 8'h00, latched);
    i_host_model.latch(8'h4E);
    i_host_model.read(d, drv);
    chk8("reset_slot", 8'h00, d);
    summarize();
  end
endmodule : tb
